/* File: core/cpc_map.svh */
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

// Register indices; byte address is four times the index
`define CPC_IDX_PROG_PROT     32'h0030_0008
`define CPC_IDX_BOOT_PROT     32'h0030_0009
`define CPC_IDX_CTRL          32'h0030_0010
`define CPC_IDX_STATUS        32'h0030_0011

// Field positions, low byte
`define CPC_BIT_BLOCK0        0
`define CPC_BIT_BLOCK1        1
// Field positions, high byte
`define CPC_BIT_BOOT          6
`define CPC_BIT_EEPROM        7
// Control register
`define CPC_BIT_ERASE         0

// Unprogrammed values and writable-bit masks
`define CPC_RST_PROG_PROT     8'h03
`define CPC_RST_BOOT_PROT     8'hc0
`define CPC_MASK_PROG_PROT    8'h03
`define CPC_MASK_BOOT_PROT    8'hc0

// Program memory boundaries
`define CPC_BOOT_END          21'h0001ff
`define CPC_BLK1_START_LARGE  21'h001000
`define CPC_BLK1_END_LARGE    21'h001fff
`define CPC_BLK1_START_SMALL  21'h000800
`define CPC_BLK1_END_SMALL    21'h000fff

// Value returned in place of protected contents
`define CPC_BLOCKED_VALUE     8'h00

// Bus responses
`define CPC_RESP_OKAY         2'h0
`define CPC_RESP_SLVERR       2'h2

`endif

/* File: core/cpc_pkg.sv */
package cpc_pkg;

    typedef enum logic [2:0] {
        CPC_REGION_BOOT,
        CPC_REGION_BLOCK0,
        CPC_REGION_BLOCK1,
        CPC_REGION_EEPROM,
        CPC_REGION_OPEN
    } cpc_region_type;

    typedef enum logic [1:0] {
        CPC_WR_IDLE,
        CPC_WR_RESP
    } cpc_wr_state_type;

endpackage

/* File: core/cpc_top.sv */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "cpc_map.svh"
module cpc_top #(
    parameter bit          LARGE_VARIANT = 1'b1,
    parameter int unsigned MEM_ADDR_W    = 21
) (
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    // AXI4-Lite write address
    input  wire logic                  i_awvalid,
    input  wire logic [31:0]           i_awaddr,
    output logic                       o_awready,
    // AXI4-Lite write data
    input  wire logic                  i_wvalid,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    output logic                       o_wready,
    // AXI4-Lite write response
    output logic                       o_bvalid,
    output logic [1:0]                 o_bresp,
    input  wire logic                  i_bready,
    // AXI4-Lite read address
    input  wire logic                  i_arvalid,
    input  wire logic [31:0]           i_araddr,
    output logic                       o_arready,
    // AXI4-Lite read data
    output logic                       o_rvalid,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    input  wire logic                  i_rready,
    // External programmer read path
    input  wire logic                  i_ext_rd_req,
    input  wire logic                  i_ext_rd_eeprom,
    input  wire logic [MEM_ADDR_W-1:0] i_ext_rd_addr,
    input  wire logic [7:0]            i_ext_mem_data,
    output logic                       o_ext_rd_ack,
    output logic [7:0]                 o_ext_rd_data,
    output logic                       o_ext_rd_blocked,
    // Protection levels to device logic
    output logic                       o_block0_protect_n,
    output logic                       o_block1_protect_n,
    output logic                       o_boot_protect_n,
    output logic                       o_eeprom_protect_n
);

    // Protection storage and refused-read count
    logic [7:0]                 prog_prot_q;
    logic [7:0]                 boot_prot_q;
    logic [7:0]                 blocked_cnt_q;

    // Write channel holding and register decode
    logic                       aw_held_q;
    logic [31:0]                awaddr_q;
    logic                       w_held_q;
    logic [31:0]                wdata_q;
    logic [3:0]                 wstrb_q;
    cpc_pkg::cpc_wr_state_type  wr_state_q;
    logic                       wr_fire;
    logic [31:0]                wr_idx;
    logic [31:0]                rd_idx;
    logic                       wr_mapped;
    logic                       rd_mapped;
    logic [31:0]                rd_word;

    // Region decode
    logic [MEM_ADDR_W-1:0]      blk1_start;
    logic [MEM_ADDR_W-1:0]      blk1_end;
    cpc_pkg::cpc_region_type    region;
    logic                       region_locked;

    assign wr_idx    = {2'h0, awaddr_q[31:2]};
    assign rd_idx    = {2'h0, i_araddr[31:2]};
    assign wr_mapped = (wr_idx == `CPC_IDX_PROG_PROT) || (wr_idx == `CPC_IDX_BOOT_PROT)
                    || (wr_idx == `CPC_IDX_CTRL) || (wr_idx == `CPC_IDX_STATUS);
    assign rd_mapped = (rd_idx == `CPC_IDX_PROG_PROT) || (rd_idx == `CPC_IDX_BOOT_PROT)
                    || (rd_idx == `CPC_IDX_CTRL) || (rd_idx == `CPC_IDX_STATUS);
    assign wr_fire   = aw_held_q && w_held_q && (wr_state_q == cpc_pkg::CPC_WR_IDLE);

    // Write address and data taken in either order
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 32'h0000_0000;
        end else if (i_awvalid && o_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= i_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= i_wdata;
            wstrb_q  <= i_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Ready drops on capture, returns once the response is taken
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                o_awready <= 1'b0;
            end else if (!aw_held_q && wr_state_q == cpc_pkg::CPC_WR_IDLE) begin
                o_awready <= 1'b1;
            end
            if (i_wvalid && o_wready) begin
                o_wready <= 1'b0;
            end else if (!w_held_q && wr_state_q == cpc_pkg::CPC_WR_IDLE) begin
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_state_q <= cpc_pkg::CPC_WR_IDLE;
            o_bvalid   <= 1'b0;
            o_bresp    <= `CPC_RESP_OKAY;
        end else begin
            case (wr_state_q)
                cpc_pkg::CPC_WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_q <= cpc_pkg::CPC_WR_RESP;
                        o_bvalid   <= 1'b1;
                        o_bresp    <= wr_mapped ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
                    end
                end
                cpc_pkg::CPC_WR_RESP: begin
                    if (i_bready) begin
                        wr_state_q <= cpc_pkg::CPC_WR_IDLE;
                        o_bvalid   <= 1'b0;
                    end
                end
                default: begin
                    wr_state_q <= cpc_pkg::CPC_WR_IDLE;
                    o_bvalid   <= 1'b0;
                end
            endcase
        end
    end

    // Protection bits; reset stands for the unprogrammed state
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            prog_prot_q <= `CPC_RST_PROG_PROT;
            boot_prot_q <= `CPC_RST_BOOT_PROT;
        end else if (wr_fire && wstrb_q[0]) begin
            if (wr_idx == `CPC_IDX_CTRL && wdata_q[`CPC_BIT_ERASE]) begin
                // Bulk erase is the only write that sets bits back to 1
                prog_prot_q <= `CPC_RST_PROG_PROT;
                boot_prot_q <= `CPC_RST_BOOT_PROT;
            end else if (wr_idx == `CPC_IDX_PROG_PROT) begin
                prog_prot_q <= prog_prot_q & wdata_q[7:0] & `CPC_MASK_PROG_PROT;
            end else if (wr_idx == `CPC_IDX_BOOT_PROT) begin
                boot_prot_q <= boot_prot_q & wdata_q[7:0] & `CPC_MASK_BOOT_PROT;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rd_idx == `CPC_IDX_PROG_PROT) begin
            rd_word[7:0] = prog_prot_q & `CPC_MASK_PROG_PROT;
        end else if (rd_idx == `CPC_IDX_BOOT_PROT) begin
            rd_word[7:0] = boot_prot_q & `CPC_MASK_BOOT_PROT;
        end else if (rd_idx == `CPC_IDX_STATUS) begin
            rd_word[7:0] = blocked_cnt_q;
        end
    end

    // One read at a time, answer one cycle after the address
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= `CPC_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_word;
            o_rresp   <= rd_mapped ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
        end else if (o_rvalid) begin
            if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end else begin
            o_arready <= 1'b1;
        end
    end

    assign blk1_start = LARGE_VARIANT ? MEM_ADDR_W'(`CPC_BLK1_START_LARGE) : MEM_ADDR_W'(`CPC_BLK1_START_SMALL);
    assign blk1_end   = LARGE_VARIANT ? MEM_ADDR_W'(`CPC_BLK1_END_LARGE) : MEM_ADDR_W'(`CPC_BLK1_END_SMALL);

    // block 0 ends where block 1 starts
    always_comb begin
        if (i_ext_rd_eeprom) begin
            region = cpc_pkg::CPC_REGION_EEPROM;
        end else if (i_ext_rd_addr <= MEM_ADDR_W'(`CPC_BOOT_END)) begin
            region = cpc_pkg::CPC_REGION_BOOT;
        end else if (i_ext_rd_addr < blk1_start) begin
            region = cpc_pkg::CPC_REGION_BLOCK0;
        end else if (i_ext_rd_addr <= blk1_end) begin
            region = cpc_pkg::CPC_REGION_BLOCK1;
        end else begin
            region = cpc_pkg::CPC_REGION_OPEN;
        end
    end

    always_comb begin
        case (region)
            cpc_pkg::CPC_REGION_BOOT:   region_locked = !boot_prot_q[`CPC_BIT_BOOT];
            cpc_pkg::CPC_REGION_BLOCK0: region_locked = !prog_prot_q[`CPC_BIT_BLOCK0];
            cpc_pkg::CPC_REGION_BLOCK1: region_locked = !prog_prot_q[`CPC_BIT_BLOCK1];
            cpc_pkg::CPC_REGION_EEPROM: region_locked = !boot_prot_q[`CPC_BIT_EEPROM];
            default:                    region_locked = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ext_rd_ack     <= 1'b0;
            o_ext_rd_data    <= 8'h00;
            o_ext_rd_blocked <= 1'b0;
        end else begin
            o_ext_rd_ack <= i_ext_rd_req;
            if (i_ext_rd_req) begin
                o_ext_rd_data    <= region_locked ? `CPC_BLOCKED_VALUE : i_ext_mem_data;
                o_ext_rd_blocked <= region_locked;
            end
        end
    end

    // Refused-read count; a refusal in the clearing cycle still counts
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            blocked_cnt_q <= 8'h00;
        end else if (i_ext_rd_req && region_locked) begin
            if (wr_fire && wr_idx == `CPC_IDX_STATUS && wstrb_q[0]) begin
                blocked_cnt_q <= 8'h01;
            end else if (blocked_cnt_q != 8'hff) begin
                blocked_cnt_q <= blocked_cnt_q + 8'h01;
            end
        end else if (wr_fire && wr_idx == `CPC_IDX_STATUS && wstrb_q[0]) begin
            blocked_cnt_q <= 8'h00;
        end
    end

    // Levels to the rest of the device
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_block0_protect_n <= 1'b1;
            o_block1_protect_n <= 1'b1;
            o_boot_protect_n   <= 1'b1;
            o_eeprom_protect_n <= 1'b1;
        end else begin
            o_block0_protect_n <= prog_prot_q[`CPC_BIT_BLOCK0];
            o_block1_protect_n <= prog_prot_q[`CPC_BIT_BLOCK1];
            o_boot_protect_n   <= boot_prot_q[`CPC_BIT_BOOT];
            o_eeprom_protect_n <= boot_prot_q[`CPC_BIT_EEPROM];
        end
    end

endmodule

/* File: dv/cpc_top_properties.sv */
`timescale 1ns/10ps
`include "cpc_map.svh"
module cpc_top_properties #(
    parameter bit          LARGE_VARIANT = 1'b1,
    parameter int unsigned MEM_ADDR_W    = 21
) (
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst,
    input wire logic                  o_rvalid,
    input wire logic [31:0]           o_rdata,
    input wire logic                  i_ext_rd_req,
    input wire logic                  i_ext_rd_eeprom,
    input wire logic [MEM_ADDR_W-1:0] i_ext_rd_addr,
    input wire logic [7:0]            i_ext_mem_data,
    input wire logic                  o_ext_rd_ack,
    input wire logic [7:0]            o_ext_rd_data,
    input wire logic                  o_ext_rd_blocked,
    input wire logic                  o_block0_protect_n,
    input wire logic                  o_block1_protect_n,
    input wire logic                  o_boot_protect_n,
    input wire logic                  o_eeprom_protect_n
);
    logic                  prg;
    logic [MEM_ADDR_W-1:0] b1s;
    logic [MEM_ADDR_W-1:0] b1e;
    assign prg = i_ext_rd_req && !i_ext_rd_eeprom;
    assign b1s = LARGE_VARIANT ? MEM_ADDR_W'(`CPC_BLK1_START_LARGE) : MEM_ADDR_W'(`CPC_BLK1_START_SMALL);
    assign b1e = LARGE_VARIANT ? MEM_ADDR_W'(`CPC_BLK1_END_LARGE) : MEM_ADDR_W'(`CPC_BLK1_END_SMALL);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    chk_ack_follows_req: assert property (i_ext_rd_req |=> o_ext_rd_ack)
        else $error("ack missing after request");
    chk_ack_one_cycle: assert property (!i_ext_rd_req |=> !o_ext_rd_ack)
        else $error("ack without request");
    chk_blocked_data_fixed: assert property (o_ext_rd_blocked |-> o_ext_rd_data == `CPC_BLOCKED_VALUE)
        else $error("blocked read leaks data");
    // Level outputs lag the stored bits by one cycle, so they match the decision one cycle on
    chk_eeprom_guard: assert property (i_ext_rd_req && i_ext_rd_eeprom
        |=> o_ext_rd_blocked == !o_eeprom_protect_n) else $error("eeprom guard wrong");
    chk_boot_guard: assert property (prg && i_ext_rd_addr <= `CPC_BOOT_END
        |=> o_ext_rd_blocked == !o_boot_protect_n) else $error("boot guard wrong");
    chk_block0_guard: assert property (prg && i_ext_rd_addr > `CPC_BOOT_END && i_ext_rd_addr < b1s
        |=> o_ext_rd_blocked == !o_block0_protect_n) else $error("block0 guard wrong");
    chk_block1_guard: assert property (prg && i_ext_rd_addr >= b1s && i_ext_rd_addr <= b1e
        |=> o_ext_rd_blocked == !o_block1_protect_n) else $error("block1 guard wrong");
    chk_open_read_data: assert property (prg && i_ext_rd_addr > b1e
        |=> !o_ext_rd_blocked && o_ext_rd_data == $past(i_ext_mem_data)) else $error("open read wrong");
    chk_upper_bits_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule
bind cpc_top cpc_top_properties #(.LARGE_VARIANT(LARGE_VARIANT), .MEM_ADDR_W(MEM_ADDR_W)) u_props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_ext_rd_req(i_ext_rd_req),
    .i_ext_rd_eeprom(i_ext_rd_eeprom), .i_ext_rd_addr(i_ext_rd_addr), .i_ext_mem_data(i_ext_mem_data),
    .o_ext_rd_ack(o_ext_rd_ack), .o_ext_rd_data(o_ext_rd_data), .o_ext_rd_blocked(o_ext_rd_blocked),
    .o_block0_protect_n(o_block0_protect_n), .o_block1_protect_n(o_block1_protect_n),
    .o_boot_protect_n(o_boot_protect_n), .o_eeprom_protect_n(o_eeprom_protect_n));

/* File: dv/cpc_top_test.sv */
`timescale 1ns/10ps
`include "cpc_map.svh"
module cpc_top_test;
    typedef struct packed {
        logic hi; logic [7:0] wd; logic [7:0] rd; logic eep; logic [20:0] ad; logic blk; logic sblk;
    } cpc_row_type;
    localparam logic [31:0] LO_A = `CPC_IDX_PROG_PROT * 4;
    localparam logic [31:0] HI_A = `CPC_IDX_BOOT_PROT * 4;
    localparam logic [31:0] CT_A = `CPC_IDX_CTRL * 4;
    localparam logic [31:0] ST_A = `CPC_IDX_STATUS * 4;
    logic i_ref_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic i_ext_rd_req, i_ext_rd_eeprom;
    logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, a;
    logic [3:0] i_wstrb;
    logic [20:0] i_ext_rd_addr;
    logic [7:0] i_ext_mem_data, o_ext_rd_data, lo, hi, nblk;
    logic [1:0] o_bresp, o_rresp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ext_rd_ack, o_ext_rd_blocked;
    logic o_block0_protect_n, o_block1_protect_n, o_boot_protect_n, o_eeprom_protect_n;
    logic s_ack, s_blk;
    logic [7:0] s_data;
    int failures, check_count;
    // Clears step down one bit at a time; 1s written in between must not come back
    // Last column: refusal expected on the 2 KB-block variant
    cpc_row_type rows [10] = '{
        '{1'b0, 8'hff, 8'h03, 1'b0, 21'h000200, 1'b0, 1'b0},
        '{1'b0, 8'hfe, 8'h02, 1'b0, 21'h000200, 1'b1, 1'b1},
        '{1'b0, 8'hff, 8'h02, 1'b0, 21'h000fff, 1'b1, 1'b0},
        '{1'b0, 8'h01, 8'h00, 1'b0, 21'h001000, 1'b1, 1'b0},
        '{1'b1, 8'hff, 8'hc0, 1'b0, 21'h0001ff, 1'b0, 1'b0},
        '{1'b1, 8'hbf, 8'h80, 1'b1, 21'h000000, 1'b0, 1'b0},
        '{1'b1, 8'h3f, 8'h00, 1'b1, 21'h000000, 1'b1, 1'b1},
        '{1'b1, 8'hff, 8'h00, 1'b0, 21'h000000, 1'b1, 1'b1},
        '{1'b0, 8'hff, 8'h00, 1'b0, 21'h002000, 1'b0, 1'b0},
        '{1'b0, 8'hff, 8'h00, 1'b0, 21'h000800, 1'b1, 1'b1}};
    cpc_top DUT (.*);
    // Second variant shares every input; only its programmer read path is watched
    cpc_top #(.LARGE_VARIANT(1'b0)) DUT_SMALL (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(),
        .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_wready(), .o_bvalid(), .o_bresp(),
        .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr), .o_arready(), .o_rvalid(),
        .o_rdata(), .o_rresp(), .i_rready(i_rready), .i_ext_rd_req(i_ext_rd_req),
        .i_ext_rd_eeprom(i_ext_rd_eeprom), .i_ext_rd_addr(i_ext_rd_addr), .i_ext_mem_data(i_ext_mem_data),
        .o_ext_rd_ack(s_ack), .o_ext_rd_data(s_data), .o_ext_rd_blocked(s_blk), .o_block0_protect_n(),
        .o_block1_protect_n(), .o_boot_protect_n(), .o_eeprom_protect_n());
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [31:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        i_awvalid <= 1'b1;
        i_awaddr  <= ad;
        i_wvalid  <= 1'b1;
        i_wdata   <= d;
        i_wstrb   <= s;
        do begin
            @(posedge i_ref_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end while ((i_awvalid && !o_awready) || (i_wvalid && !o_wready));
        i_bready <= 1'b1;
        do @(posedge i_ref_clk); while (!o_bvalid);
        chk(o_bresp, er);
        i_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [31:0] ad, input logic [31:0] exp, input logic [1:0] er);
        i_arvalid <= 1'b1;
        i_araddr  <= ad;
        do @(posedge i_ref_clk); while (!o_arready);
        i_arvalid <= 1'b0;
        i_rready  <= 1'b1;
        do @(posedge i_ref_clk); while (!o_rvalid);
        chk(o_rresp, er);
        if (er === `CPC_RESP_OKAY) chk(o_rdata, exp);
        i_rready <= 1'b0;
    endtask
    task automatic ext_rd(input logic e, input logic [20:0] ad, input logic [7:0] d, input logic blk,
                          input logic sblk);
        @(posedge i_ref_clk);
        i_ext_rd_req    <= 1'b1;
        i_ext_rd_eeprom <= e;
        i_ext_rd_addr   <= ad;
        i_ext_mem_data  <= d;
        @(posedge i_ref_clk);
        i_ext_rd_req    <= 1'b0;
        i_ext_mem_data  <= ~d;
        // Ack stands one cycle; sampled at the edge that ends it, so drives stay on edges
        @(posedge i_ref_clk);
        chk(o_ext_rd_ack, 1);
        chk(o_ext_rd_blocked, blk);
        chk(o_ext_rd_data, blk ? `CPC_BLOCKED_VALUE : d);
        chk(s_ack, 1);
        chk(s_blk, sblk);
        chk(s_data, sblk ? `CPC_BLOCKED_VALUE : d);
    endtask
    task automatic finish_test;
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        finish_test();
    end
    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_ext_rd_req, i_ext_rd_eeprom} <= '0;
        {i_awaddr, i_wdata, i_araddr, i_wstrb, i_ext_rd_addr, i_ext_mem_data} <= '0;
        i_rst <= 1'b1;
        nblk = 8'h00;
        // Expected levels start from the unprogrammed bytes
        lo = `CPC_RST_PROG_PROT;
        hi = `CPC_RST_BOOT_PROT;
        repeat (6) @(posedge i_ref_clk);
        chk({o_eeprom_protect_n, o_boot_protect_n, o_block1_protect_n, o_block0_protect_n}, 4'hf);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        for (int i = 0; i < 10; i++) begin
            a = rows[i].hi ? HI_A : LO_A;
            axi_wr(a, {24'h0, rows[i].wd}, 4'h1, `CPC_RESP_OKAY);
            axi_rd(a, {24'h0, rows[i].rd}, `CPC_RESP_OKAY);
            if (rows[i].hi) hi = rows[i].rd;
            else lo = rows[i].rd;
            ext_rd(rows[i].eep, rows[i].ad, 8'h30 + i[7:0],
                   rows[i].blk, rows[i].sblk);
            chk({o_eeprom_protect_n, o_boot_protect_n, o_block1_protect_n, o_block0_protect_n},
                {hi[7:6], lo[1:0]});
            nblk = nblk + rows[i].blk;
        end
        axi_rd(ST_A, {24'h0, nblk}, `CPC_RESP_OKAY);
        axi_wr(ST_A, 32'h0, 4'h1, `CPC_RESP_OKAY);
        axi_rd(ST_A, 32'h0, `CPC_RESP_OKAY);
        axi_wr(CT_A, 32'h1, 4'h1, `CPC_RESP_OKAY);
        axi_rd(CT_A, 32'h0, `CPC_RESP_OKAY);
        axi_rd(LO_A, 32'h3, `CPC_RESP_OKAY);
        axi_rd(HI_A, 32'hc0, `CPC_RESP_OKAY);
        // Strobe off must leave the bits alone
        axi_wr(LO_A, 32'h0, 4'h0, `CPC_RESP_OKAY);
        axi_rd(LO_A, 32'h3, `CPC_RESP_OKAY);
        axi_wr(32'h100, 32'h0, 4'h1, `CPC_RESP_SLVERR);
        axi_rd(32'h100, 32'h0, `CPC_RESP_SLVERR);
        // Mid-run reset restores unprogrammed levels
        axi_wr(HI_A, 32'h0, 4'h1, `CPC_RESP_OKAY);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        chk({o_eeprom_protect_n, o_boot_protect_n}, 2'h3);
        axi_rd(HI_A, 32'hc0, `CPC_RESP_OKAY);
        finish_test();
    end
endmodule
